// ### dv/angle_limit_alarm_properties.sv
// assertions on the object port, state bytes, pdo record and emergency outputs
// assumes the single clock and active low async reset of the top module
module angle_limit_alarm_properties
  import angle_limit_alarm_pkg::*;
(
  input wire logic        i_clk,           // clock
  input wire logic        i_nrst,          // reset, active low
  input wire logic        i_od_req,        // access request
  input wire logic        i_od_wr,         // write select
  input wire logic [15:0] i_od_index,      // object index
  input wire logic [7:0]  i_od_sub,        // sub-index
  input wire logic        o_od_ack,        // access done
  input wire logic        o_od_err,        // access refused
  input wire logic [31:0] o_od_rdata,      // read data
  input wire logic        i_coupling_lost, // fault level
  input wire logic [6:0]  i_node_id,       // node number
  input wire logic [7:0]  o_area_state_1,  // state byte 1
  input wire logic [7:0]  o_area_state_2,  // state byte 2
  input wire logic        o_pdo_valid,     // record valid
  input wire logic        i_pdo_ready,     // record accepted
  input wire logic [47:0] o_pdo_data,      // record
  input wire logic        o_emcy_valid,    // emergency pending
  input wire logic        i_emcy_ready,    // emergency accepted
  input wire logic [10:0] o_emcy_id,       // emergency id
  input wire logic [15:0] o_emcy_code      // emergency code
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  // ----
  // object port
  // ----
  ack_follows_req_a: assert property (i_od_req |=> o_od_ack)
    else $error("access not answered in the next cycle");
  ack_has_cause_a: assert property (o_od_ack |-> $past(i_od_req))
    else $error("answer without a request");
  idle_quiet_a: assert property (!o_od_ack |-> !o_od_err && o_od_rdata == 32'h0)
    else $error("error or data outside an answer");
  cap_read_a: assert property (i_od_req && !i_od_wr && i_od_index == IDX_FAULT_CAP && i_od_sub == 8'h00
    |=> !o_od_err && o_od_rdata == 32'h0000_8000) else $error("supported alarms word wrong");
  fault_read_a: assert property (i_od_req && !i_od_wr && i_od_index == IDX_FAULT && i_od_sub == 8'h00
    |=> o_od_rdata == {16'h0, $past(i_coupling_lost, 2), 15'h0}) else $error("alarm word wrong");
  // ----
  // state bytes, record, emergency
  // ----
  state_code_a: assert property (o_area_state_1 inside {8'h00, 8'h03, 8'h05}
    && o_area_state_2 inside {8'h00, 8'h03, 8'h05}) else $error("illegal state byte");
  record_fields_a: assert property (o_pdo_valid |-> o_pdo_data[47:16] <= 32'd327680
    && o_pdo_data[15:8] inside {8'h00, 8'h03, 8'h05}) else $error("record fields illegal");
  record_hold_a: assert property (o_pdo_valid && !i_pdo_ready |=> o_pdo_valid && $stable(o_pdo_data))
    else $error("record dropped or changed while waiting");
  emcy_raise_a: assert property ($rose(i_coupling_lost) |=> o_emcy_valid && o_emcy_code == 16'h1000
    && o_emcy_id == 11'h080 + {4'h0, $past(i_node_id)}) else $error("emergency not raised");
  emcy_hold_a: assert property (o_emcy_valid && !i_emcy_ready |=> o_emcy_valid && $stable(o_emcy_id))
    else $error("emergency dropped before acceptance");
endmodule

bind angle_limit_alarm_objects angle_limit_alarm_properties props (.*);

// ### dv/pdo_far_side.sv
// far side model: pdo transmitter and emergency consumer of the bus side
// assumes the design's clock; readies move just after the rising edge
module pdo_far_side
(
  input  wire logic        i_clk,        // clock
  input  wire logic        i_stall,      // hold both readies low
  input  wire logic        i_pdo_valid,  // record offered
  input  wire logic [47:0] i_pdo_data,   // record
  output logic             o_pdo_ready,  // record accepted
  output logic             o_emcy_ready, // emergency accepted
  output int               o_pdo_cnt,    // records taken
  output logic [47:0]      o_last        // last record taken
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    o_pdo_ready = 1'b0;
    o_emcy_ready = 1'b0;
    o_pdo_cnt = 0;
    o_last = '0;
  end
  // prompt or stalled acceptance as the bench commands; taken on the rising
  // edge so a falling-edge change of stall never races this update
  always @(posedge i_clk)
  begin
    o_pdo_ready <= !i_stall;
    o_emcy_ready <= !i_stall;
  end
  always @(posedge i_clk)
  begin
    if (i_pdo_valid && o_pdo_ready)
    begin
      o_pdo_cnt <= o_pdo_cnt + 1;
      o_last <= i_pdo_data;
    end
  end
endmodule

// ### dv/test_angle_limit_alarm_objects.sv
// self-checking bench of the angle limit and alarm objects
// assumes the far side model and the bound property checker
module test_angle_limit_alarm_objects;
  timeunit 1ns;
  timeprecision 1ns;
  import angle_limit_alarm_pkg::*;
  localparam int MS = 4;
  localparam int DEPTH = 8;
  logic        i_clk, i_nrst, i_od_req, i_od_wr, i_coupling_lost, stall, rerr;
  logic [15:0] i_od_index, i_op_params, i_revolutions;
  logic [7:0]  i_od_sub;
  logic [31:0] i_od_wdata, i_position, i_resolution, rd;
  logic [6:0]  i_node_id;
  wire         o_od_ack, o_od_err, o_pdo_valid, i_pdo_ready, o_emcy_valid, i_emcy_ready;
  wire  [31:0] o_od_rdata, o_position_raw;
  wire  [7:0]  o_area_state_1, o_area_state_2;
  wire  [47:0] o_pdo_data, last;
  wire  [10:0] o_emcy_id;
  wire  [15:0] o_emcy_code;
  int          error_cnt, tests_run, n, c0, pdo_cnt, l, lo[2], hi[2];
  int          plist[7] = '{1800, 3000, 500, 3600, 900, 327680, 0};
  integer      seed;

  angle_limit_alarm_objects #(.MS_CYCLES(MS), .FIFO_DEPTH(DEPTH)) dut (.*);
  pdo_far_side far (.i_clk(i_clk), .i_stall(stall), .i_pdo_valid(o_pdo_valid), .i_pdo_data(o_pdo_data),
    .o_pdo_ready(i_pdo_ready), .o_emcy_ready(i_emcy_ready), .o_pdo_cnt(pdo_cnt), .o_last(last));

  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // ----
  // model and tasks
  // ----
  function automatic logic [7:0] area(int p, int lw, int hg);
    return p > hg ? 8'h03 : (p < lw ? 8'h05 : 8'h00);
  endfunction
  function automatic int rnd(int m);
    return $unsigned($random(seed)) % m;
  endfunction
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic od(input logic w, input logic [15:0] idx, input logic [7:0] s, input logic [31:0] d);
    @(negedge i_clk);
    i_od_req = 1'b1;
    i_od_wr = w;
    i_od_index = idx;
    i_od_sub = s;
    i_od_wdata = d;
    @(negedge i_clk);
    i_od_req = 1'b0;
    rd = o_od_rdata;
    rerr = o_od_err;
    chk("ack", 1'b1, o_od_ack);
  endtask
  task automatic rdchk(input logic [15:0] idx, input logic [7:0] s, input logic [31:0] exp, input logic e);
    od(1'b0, idx, s, 32'h0);
    chk($sformatf("rdata %h.%h", idx, s), exp, rd);
    chk($sformatf("err %h.%h", idx, s), e, rerr);
  endtask
  task automatic wrchk(input logic [15:0] idx, input logic [7:0] s, input logic [31:0] d, input logic e);
    od(1'b1, idx, s, d);
    chk($sformatf("write err %h.%h", idx, s), e, rerr);
  endtask
  task automatic setlim(input int ch, input int lw, input int hg);
    // order the two writes so that low never passes high on the way
    if (lw > hi[ch])
      wrchk(IDX_HIGH_BOUND, 8'(ch + 1), hg, 1'b0);
    wrchk(IDX_LOW_BOUND, 8'(ch + 1), lw, 1'b0);
    if (lw <= hi[ch])
      wrchk(IDX_HIGH_BOUND, 8'(ch + 1), hg, 1'b0);
    lo[ch] = lw;
    hi[ch] = hg;
  endtask
  task automatic st_chk();
    repeat (3) @(negedge i_clk);
    chk("raw position", i_position, o_position_raw);
    chk("state 1", area(i_position, lo[0], hi[0]), o_area_state_1);
    chk("state 2", area(i_position, lo[1], hi[1]), o_area_state_2);
    rdchk(IDX_AREA_STATE, SUB_CH1, area(i_position, lo[0], hi[0]), 1'b0);
    rdchk(IDX_AREA_STATE, SUB_CH2, area(i_position, lo[1], hi[1]), 1'b0);
  endtask
  task automatic wait_valid(input logic lvl);
    while (o_pdo_valid !== lvl)
    begin
      @(negedge i_clk);
      n++;
      if (n > 2000)
      begin
        error_cnt++;
        finish_test();
      end
    end
  endtask
  // ----
  // main sequence
  // ----
  initial
  begin
    seed = 32'he690;
    {i_nrst, i_od_req, i_od_wr, i_coupling_lost, stall} = '0;
    {i_od_index, i_od_sub, i_od_wdata, i_position} = '0;
    i_node_id = 7'($random(seed));
    {i_op_params, i_resolution, i_revolutions} = '0;
    repeat (2) @(negedge i_clk);
    i_nrst = 1'b1;
    rdchk(IDX_CYCLE_TIMER, SUB_COUNT, 32'h0000_0064, 1'b0);
    rdchk(IDX_LOW_BOUND, SUB_CH2, 32'h0, 1'b0);
    rdchk(IDX_HIGH_BOUND, SUB_CH1, 32'h0, 1'b0);
    rdchk(IDX_AREA_STATE, SUB_COUNT, 32'h2, 1'b0);
    rdchk(IDX_HIGH_BOUND, SUB_COUNT, 32'h2, 1'b0);
    rdchk(IDX_FAULT_CAP, SUB_COUNT, 32'h0000_8000, 1'b0);
    wrchk(IDX_AREA_STATE, SUB_CH1, 32'h0, 1'b1);
    wrchk(IDX_LOW_BOUND, SUB_CH1, 32'd327681, 1'b1);
    wrchk(IDX_HIGH_BOUND, SUB_CH2, 32'h8000_0000, 1'b1);
    wrchk(IDX_CYCLE_TIMER, SUB_COUNT, 32'h0001_0000, 1'b1);
    wrchk(16'h6300, SUB_COUNT, 32'h0, 1'b1);
    rdchk(IDX_LOW_BOUND, SUB_CH1, 32'h0, 1'b0);
    wrchk(IDX_CYCLE_TIMER, SUB_COUNT, 32'h0000_ffff, 1'b0);
    rdchk(IDX_CYCLE_TIMER, SUB_COUNT, 32'h0000_ffff, 1'b0);
    setlim(0, 900, 3600);
    setlim(1, 2700, 327680);
    for (int k = 0; k < 13; k++)
    begin
      if (k >= 7)
      begin
        l = rnd(163841);
        setlim(1, l, l + rnd(163840));
      end
      i_position = k < 7 ? plist[k] : rnd(327681);
      st_chk();
    end
    for (int k = 0; k < 3; k++)
    begin
      i_op_params = 16'($random(seed));
      i_resolution = $random(seed);
      i_revolutions = 16'($random(seed));
      rdchk(IDX_OP_STATUS, SUB_COUNT, {16'h0, i_op_params}, 1'b0);
      rdchk(IDX_RESOLUTION, SUB_COUNT, i_resolution, 1'b0);
      rdchk(IDX_REVOLUTIONS, SUB_COUNT, {16'h0, i_revolutions}, 1'b0);
      wrchk(IDX_REVOLUTIONS, SUB_COUNT, 32'h1, 1'b1);
    end
    wrchk(IDX_CYCLE_TIMER, SUB_COUNT, 32'd0, 1'b0);
    stall = 1'b1;
    i_coupling_lost = 1'b1;
    repeat (4) @(negedge i_clk);
    chk("emcy valid", 1'b1, o_emcy_valid);
    chk("emcy id", 11'h080 + i_node_id, o_emcy_id);
    chk("emcy code", 16'h1000, o_emcy_code);
    rdchk(IDX_FAULT, SUB_COUNT, 32'h0000_8000, 1'b0);
    stall = 1'b0;
    i_coupling_lost = 1'b0;
    repeat (4) @(negedge i_clk);
    chk("emcy taken", 1'b0, o_emcy_valid);
    rdchk(IDX_FAULT, SUB_COUNT, 32'h0, 1'b0);
    i_position = 32'd12345;
    wrchk(IDX_CYCLE_TIMER, SUB_COUNT, 32'd3, 1'b0);
    n = 0;
    wait_valid(1'b1);
    chk("first delay", 1'b1, n >= 3 * MS - 1 && n <= 3 * MS + 6);
    chk("record", {i_position, area(12345, lo[0], hi[0]), area(12345, lo[1], hi[1])}, o_pdo_data);
    n = 0;
    wait_valid(1'b0);
    wait_valid(1'b1);
    chk("interval", 3 * MS, n);
    stall = 1'b1;
    repeat (60 * MS) @(negedge i_clk);
    wrchk(IDX_CYCLE_TIMER, SUB_COUNT, 32'd0, 1'b0);
    c0 = pdo_cnt;
    stall = 1'b0;
    repeat (60) @(negedge i_clk);
    chk("burst", 1'b1, pdo_cnt - c0 >= DEPTH && pdo_cnt - c0 <= DEPTH + 1);
    c0 = pdo_cnt;
    repeat (200) @(negedge i_clk);
    chk("idle records", c0, pdo_cnt);
    chk("last record", {i_position, area(12345, lo[0], hi[0]), area(12345, lo[1], hi[1])}, last);
    wrchk(IDX_CYCLE_TIMER, SUB_COUNT, 32'd100, 1'b0);
    repeat (100 * MS + 8) @(negedge i_clk);
    chk("restored records", c0 + 1, pdo_cnt);
    i_nrst = 1'b0;
    repeat (2) @(negedge i_clk);
    i_nrst = 1'b1;
    rdchk(IDX_CYCLE_TIMER, SUB_COUNT, 32'h0000_0064, 1'b0);
    rdchk(IDX_HIGH_BOUND, SUB_CH2, 32'h0, 1'b0);
    finish_test();
  end
endmodule

// ### hw/angle_limit_alarm_objects.sv
// limit, cycle timer and alarm objects of the angle sensor object dictionary
// assumes the protocol stack hands object accesses over a request/ack port and
// that position and configuration inputs come from logic on the same clock
module angle_limit_alarm_objects
  import angle_limit_alarm_pkg::*;
#(
  parameter int MS_CYCLES  = angle_limit_alarm_pkg::CYCLES_PER_MS,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        i_clk,            // 10 MHz clock
  input  wire logic        i_nrst,           // async reset, active low
  input  wire logic        i_od_req,         // object access request, one cycle
  input  wire logic        i_od_wr,          // 1 write, 0 read
  input  wire logic [15:0] i_od_index,       // object index
  input  wire logic [7:0]  i_od_sub,         // sub-index
  input  wire logic [31:0] i_od_wdata,       // write data
  output logic             o_od_ack,         // access done, one cycle
  output logic             o_od_err,         // access refused, with ack
  output logic [31:0]      o_od_rdata,       // read data, with ack
  input  wire logic [31:0] i_position,       // unscaled position
  input  wire logic [15:0] i_op_params,      // operating parameter settings
  input  wire logic [31:0] i_resolution,     // configured single-turn resolution
  input  wire logic [15:0] i_revolutions,    // distinguishable revolutions
  input  wire logic        i_coupling_lost,  // coil coupling fault level
  input  wire logic [6:0]  i_node_id,        // node number
  output logic [31:0]      o_position_raw,   // registered unscaled position
  output logic [7:0]       o_area_state_1,   // channel 1 state byte
  output logic [7:0]       o_area_state_2,   // channel 2 state byte
  output logic             o_pdo_valid,      // pdo record valid
  input  wire logic        i_pdo_ready,      // pdo transmitter accepts
  output logic [47:0]      o_pdo_data,       // position, state 1, state 2
  output logic             o_emcy_valid,     // emergency pending
  input  wire logic        i_emcy_ready,     // emergency accepted
  output logic [10:0]      o_emcy_id,        // emergency identifier
  output logic [15:0]      o_emcy_code       // emergency error code
);
  import angle_limit_alarm_pkg::*;

  localparam int MW = $clog2(MS_CYCLES + 1);

  if (MS_CYCLES < 1)
  begin : g_bad_ms
    $error("MS_CYCLES must be at least 1");
  end

  // ---------------------------------------------------------------
  // object registers
  // ---------------------------------------------------------------
  logic [15:0] cyclic_output_period;
  logic [31:0] area_low_bound  [2];
  logic [31:0] area_high_bound [2];
  logic [7:0]  area_state_flags [2];
  logic [15:0] fault_word;

  wire is_sub_ch   = (i_od_sub == SUB_CH1) || (i_od_sub == SUB_CH2);
  wire ch_sel      = (i_od_sub == SUB_CH2);
  wire sel_cycle   = (i_od_index == IDX_CYCLE_TIMER) && (i_od_sub == SUB_COUNT);
  wire sel_state   = (i_od_index == IDX_AREA_STATE);
  wire sel_low     = (i_od_index == IDX_LOW_BOUND);
  wire sel_high    = (i_od_index == IDX_HIGH_BOUND);
  wire sel_array   = sel_state || sel_low || sel_high;
  wire sel_var     = (i_od_sub == SUB_COUNT) &&
                     ((i_od_index == IDX_OP_STATUS) || (i_od_index == IDX_RESOLUTION) ||
                      (i_od_index == IDX_REVOLUTIONS) || (i_od_index == IDX_FAULT) ||
                      (i_od_index == IDX_FAULT_CAP));
  wire bound_ok    = !i_od_wdata[31] && (i_od_wdata <= POS_MAX);
  wire cycle_ok    = (i_od_wdata[31:16] == 16'h0000);
  wire wr_cycle    = i_od_req && i_od_wr && sel_cycle && cycle_ok;
  wire wr_bound    = i_od_req && i_od_wr && (sel_low || sel_high) && is_sub_ch && bound_ok;
  wire known       = sel_cycle || sel_var || (sel_array && (is_sub_ch || i_od_sub == SUB_COUNT));
  wire wr_refused  = i_od_wr && !(wr_cycle || wr_bound);
  wire next_err    = !known || wr_refused;

  logic [31:0] read_mux;
  always_comb
  begin
    read_mux = 32'h0000_0000;
    if (sel_array && i_od_sub == SUB_COUNT)
      read_mux = {24'h00_0000, CHANNEL_COUNT};
    else if (sel_state)
      read_mux = {24'h00_0000, area_state_flags[ch_sel]};
    else if (sel_low)
      read_mux = area_low_bound[ch_sel];
    else if (sel_high)
      read_mux = area_high_bound[ch_sel];
    else
    begin
      case (i_od_index)
        IDX_CYCLE_TIMER: read_mux = {16'h0000, cyclic_output_period};
        IDX_OP_STATUS:   read_mux = {16'h0000, i_op_params};
        IDX_RESOLUTION:  read_mux = i_resolution;
        IDX_REVOLUTIONS: read_mux = {16'h0000, i_revolutions};
        IDX_FAULT:       read_mux = {16'h0000, fault_word};
        IDX_FAULT_CAP:   read_mux = {16'h0000, FAULT_CAP_VALUE};
        default:         read_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_od_ack   <= 1'b0;
      o_od_err   <= 1'b0;
      o_od_rdata <= 32'h0000_0000;
    end
    else
    begin
      o_od_ack   <= i_od_req;
      o_od_err   <= i_od_req && next_err;
      o_od_rdata <= (i_od_req && !i_od_wr && known) ? read_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      cyclic_output_period <= CYCLE_TIMER_RST;
    else if (wr_cycle)
      cyclic_output_period <= i_od_wdata[15:0];
  end

  // ---------------------------------------------------------------
  // limit channels
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_position_raw <= 32'h0000_0000;
    else
      o_position_raw <= i_position;
  end

  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    wire wr_this = wr_bound && (ch_sel == 1'(c));
    wire above   = $signed(o_position_raw) > $signed(area_high_bound[c]);
    wire below   = $signed(o_position_raw) < $signed(area_low_bound[c]);
    logic [7:0] next_state;
    always_comb
    begin
      next_state = 8'h00;
      next_state[ST_ABOVE_BIT]   = above;
      next_state[ST_BELOW_BIT]   = below;
      next_state[ST_OUTSIDE_BIT] = above || below;
    end
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
      if (!i_nrst)
      begin
        area_low_bound[c]   <= BOUND_RST;
        area_high_bound[c]  <= BOUND_RST;
        area_state_flags[c] <= 8'h00;
      end
      else
      begin
        if (wr_this && sel_low)
          area_low_bound[c] <= i_od_wdata;
        if (wr_this && sel_high)
          area_high_bound[c] <= i_od_wdata;
        area_state_flags[c] <= next_state;
      end
    end
  end

  assign o_area_state_1 = area_state_flags[0];
  assign o_area_state_2 = area_state_flags[1];

  // ---------------------------------------------------------------
  // cycle timer
  // ---------------------------------------------------------------
  logic [MW-1:0] ms_count;
  logic [15:0]   period_count;
  logic          pdo_pending;
  logic          fifo_in_ready;
  wire           ms_tick    = (ms_count == MW'(MS_CYCLES - 1));
  wire           period_end = ms_tick && (period_count == cyclic_output_period - 16'h0001);
  wire           timer_on   = (cyclic_output_period != 16'h0000);

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ms_count     <= '0;
      period_count <= 16'h0000;
      pdo_pending  <= 1'b0;
    end
    else
    begin
      if (wr_cycle || ms_tick)
        ms_count <= '0;
      else
        ms_count <= ms_count + 1'b1;
      if (wr_cycle || !timer_on || period_end)
        period_count <= 16'h0000;
      else if (ms_tick)
        period_count <= period_count + 16'h0001;
      if (!timer_on || wr_cycle)
        pdo_pending <= 1'b0;
      else if (period_end)
        pdo_pending <= 1'b1;
      else if (fifo_in_ready)
        pdo_pending <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // pdo record path
  // ---------------------------------------------------------------
  logic          fifo_out_valid;
  logic [47:0]   fifo_out_data;
  wire           out_load = fifo_out_valid && (!o_pdo_valid || i_pdo_ready);

  pdo_fifo #(
    .WIDTH (PDO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_valid (pdo_pending),
    .o_ready (fifo_in_ready),
    .i_data  ({o_position_raw, area_state_flags[0], area_state_flags[1]}),
    .o_valid (fifo_out_valid),
    .i_ready (out_load),
    .o_data  (fifo_out_data)
  );

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_pdo_valid <= 1'b0;
      o_pdo_data  <= 48'h0000_0000_0000;
    end
    else
    begin
      if (out_load)
        o_pdo_data <= fifo_out_data;
      if (out_load)
        o_pdo_valid <= 1'b1;
      else if (i_pdo_ready)
        o_pdo_valid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // alarm and emergency
  // ---------------------------------------------------------------
  wire alarm_rise = i_coupling_lost && !fault_word[FAULT_COUPLING_BIT];

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      fault_word   <= 16'h0000;
      o_emcy_valid <= 1'b0;
      o_emcy_id    <= 11'h000;
      o_emcy_code  <= 16'h0000;
    end
    else
    begin
      fault_word[FAULT_COUPLING_BIT] <= i_coupling_lost;
      if (alarm_rise)
      begin
        o_emcy_valid <= 1'b1;
        o_emcy_id    <= EMCY_BASE_ID + {4'h0, i_node_id};
        o_emcy_code  <= EMCY_CODE_GENERIC;
      end
      else if (i_emcy_ready)
        o_emcy_valid <= 1'b0;
    end
  end
endmodule

// ### hw/angle_limit_alarm_pkg.sv
// constants of the angle limit and alarm object block
// assumes one 10 MHz functional clock and an object access port driven by the protocol stack
// How it works
// - position is pushed cyclically toward the first transmit pdo at the cycle timer period
// - cyclic output runs while the cycle timer is nonzero; at zero no new record is queued, records already queued still go out
// - cycle timer holds 16-bit milliseconds, 0 to 0xffff, reset value 0x64
// - state byte is 0x00, unused bits too, while position is inside range
// - position above high limit gives state byte 0x03
// - position below low limit gives state byte 0x05
// - two independent channels, each state byte in its own sub-index
// - low and high limit objects each hold two signed 32-bit values by sub-index
// - limits span 0 to 327680 and reset to zero
// - state bytes travel with the process data record
// - operating status reads as a 16-bit copy of the operating parameters
// - resolution object reads the configured 32-bit single-turn resolution
// - revolution count object reads the distinguishable revolutions, 16 bits
// - alarm bit 15 stays set while coupling is lost, bits 0 to 14 reserved
// - raising the alarm sends emergency 0x80 plus node number with code 0x1000
// - supported alarms reads with bit 15 set, other bits zero
// - unscaled position 0 to 327680 is exposed and used for limits
package angle_limit_alarm_pkg;
  // object indexes
  localparam logic [15:0] IDX_CYCLE_TIMER  = 16'h6200;
  localparam logic [15:0] IDX_AREA_STATE   = 16'h6400;
  localparam logic [15:0] IDX_LOW_BOUND    = 16'h6401;
  localparam logic [15:0] IDX_HIGH_BOUND   = 16'h6402;
  localparam logic [15:0] IDX_OP_STATUS    = 16'h6500;
  localparam logic [15:0] IDX_RESOLUTION   = 16'h6501;
  localparam logic [15:0] IDX_REVOLUTIONS  = 16'h6502;
  localparam logic [15:0] IDX_FAULT        = 16'h6503;
  localparam logic [15:0] IDX_FAULT_CAP    = 16'h6504;
  localparam logic [7:0]  SUB_COUNT        = 8'h00;
  localparam logic [7:0]  SUB_CH1          = 8'h01;
  localparam logic [7:0]  SUB_CH2          = 8'h02;
  localparam logic [7:0]  CHANNEL_COUNT    = 8'h02;
  // reset values and ranges
  localparam logic [15:0] CYCLE_TIMER_RST  = 16'h0064;
  localparam logic [31:0] BOUND_RST        = 32'h0000_0000;
  localparam logic [31:0] POS_MAX          = 32'h0005_0000;
  // state byte fields
  localparam int          ST_OUTSIDE_BIT   = 0;
  localparam int          ST_ABOVE_BIT     = 1;
  localparam int          ST_BELOW_BIT     = 2;
  // alarm words
  localparam int          FAULT_COUPLING_BIT = 15;
  localparam logic [15:0] FAULT_CAP_VALUE  = 16'h8000;
  // emergency message
  localparam logic [10:0] EMCY_BASE_ID     = 11'h080;
  localparam logic [15:0] EMCY_CODE_GENERIC = 16'h1000;
  // timing
  localparam int          CLK_FREQ_HZ      = 10_000_000;
  localparam int          TICK_PERIOD_MS   = 1;
  localparam int          MS_PER_S         = 1000;
  localparam int          CYCLES_PER_MS    = CLK_FREQ_HZ / MS_PER_S * TICK_PERIOD_MS;
  // process data record: position, state channel 1, state channel 2
  localparam int          PDO_WIDTH        = 48;
endpackage

// ### hw/pdo_fifo.sv
// fifo of process data records between the cycle logic and the pdo transmitter
// assumes both sides on the same clock
module pdo_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,    // clock
  input  wire logic             i_nrst,   // async reset, active low
  input  wire logic             i_valid,  // write request
  output logic                  o_ready,  // not full
  input  wire logic [WIDTH-1:0] i_data,   // write data
  output logic                  o_valid,  // not empty
  input  wire logic             i_ready,  // read accept
  output logic [WIDTH-1:0]      o_data    // head entry
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("pdo_fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = i_valid && o_ready;
  wire              pop  = o_valid && i_ready;

  assign o_ready = (count != (AW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign o_data  = mem[rd_ptr];

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_ptr] <= i_data;
  end
endmodule
